/* spi_eeprom_map.vh */
`ifndef SPI_EEPROM_MAP_VH
`define SPI_EEPROM_MAP_VH

// ----------------------------------------
// Opcodes, compared under the don't-care mask
// ----------------------------------------
`define OPCODE_MASK 8'hf7
`define SET_WRITE_LATCH_CMD 8'h06
`define CLEAR_WRITE_LATCH_CMD 8'h04
`define STATUS_READ_CMD 8'h05
`define STATUS_WRITE_CMD 8'h01
`define ARRAY_READ_CMD 8'h03
`define ARRAY_WRITE_CMD 8'h02

// ----------------------------------------
// Status byte field positions
// ----------------------------------------
`define PROTECT_PIN_ENABLE_BIT 7
`define BLOCK_PROTECT_HI_BIT 3
`define BLOCK_PROTECT_LO_BIT 2
`define WRITE_LATCH_BIT 1
`define BUSY_BIT 0
`define STATUS_BUSY_VALUE 8'hff

// ----------------------------------------
// Reset values of the nonvolatile protection bits
// ----------------------------------------
`define PROTECT_PIN_ENABLE_RESET 1'b0
`define BLOCK_PROTECT_RESET 2'b00

// ----------------------------------------
// Geometry and timing
// ----------------------------------------
`define ADDR_BITS_SMALL 14
`define PAGE_BITS 6
`define WRITE_CYCLE_MS 5
`define CLK_FREQ_KHZ 100000
`define WRITE_CYCLE_CLKS (`WRITE_CYCLE_MS * `CLK_FREQ_KHZ)
`define PROG_CNT_BITS 20

`endif

/* link_sampler.v */
`timescale 1ns/1ps

module link_sampler (
  input wire clk_i,
  input wire reset_n_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  input wire wp_n_i,
  output reg cs_n_o,
  output reg si_o,
  output reg wp_n_o,
  output reg sck_rise_o,
  output reg sck_fall_o,
  output reg cs_fall_o,
  output reg cs_rise_o
);

  // ----------------------------------------
  // Two-stage synchronisers; edges look only at the second stage
  // ----------------------------------------
  reg [3:0] meta;
  reg sck_s;
  reg sck_d;
  reg cs_d;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= 4'h9;
      cs_n_o <= 1'b1;
      sck_s <= 1'b0;
      si_o <= 1'b0;
      wp_n_o <= 1'b1;
      sck_d <= 1'b0;
      cs_d <= 1'b1;
      sck_rise_o <= 1'b0;
      sck_fall_o <= 1'b0;
      cs_fall_o <= 1'b0;
      cs_rise_o <= 1'b0;
    end else begin
      meta <= {wp_n_i, si_i, sck_i, cs_n_i};
      cs_n_o <= meta[0];
      sck_s <= meta[1];
      si_o <= meta[2];
      wp_n_o <= meta[3];
      sck_d <= sck_s;
      cs_d <= cs_n_o;
      sck_rise_o <= sck_s & ~sck_d;
      sck_fall_o <= ~sck_s & sck_d;
      cs_fall_o <= ~cs_n_o & cs_d;
      cs_rise_o <= cs_n_o & ~cs_d;
    end
  end

endmodule // link_sampler

/* byte_buffer2.v */
`timescale 1ns/1ps

module byte_buffer2 #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter PTR_W = 1
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire flush_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  localparam [PTR_W-1:0] PTR_ONE = 1;
  localparam [PTR_W:0] CNT_ONE = 1;
  localparam [PTR_W:0] CNT_FULL = DEPTH;

  reg [WIDTH-1:0] slot [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr;
  reg [PTR_W-1:0] rd_ptr;
  reg [PTR_W:0] count;
  wire push;
  wire pop;

  assign in_ready_o = (count != CNT_FULL);
  assign out_valid_o = (count != {(PTR_W+1){1'b0}});
  assign out_data_o = slot[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_ready_i & out_valid_o;

  always @(posedge clk_i) begin
    if (push && !flush_i) begin
      slot[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      count <= {(PTR_W+1){1'b0}};
    end else if (flush_i) begin
      wr_ptr <= {PTR_W{1'b0}};
      rd_ptr <= {PTR_W{1'b0}};
      count <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PTR_ONE;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PTR_ONE;
      end
      if (push && !pop) begin
        count <= count + CNT_ONE;
      end else if (pop && !push) begin
        count <= count - CNT_ONE;
      end
    end
  end

endmodule // byte_buffer2

/* spi_eeprom_command_core.v */
// Notes on behaviour
// - Opcode 0000x110 sets the write-enable latch.
// - Opcode 0000x100 clears the write-enable latch.
// - 0000x011 reads the array, 0000x010 writes it; bit 3 ignored.
// - 0000x101 reads status, 0000x001 writes status; bit 3 ignored.
// - All bytes travel MSB first; each command starts on chip select falling.
// - Latch clear after reset; master sets it before each programming command.
// - Clearing the latch blocks programming regardless of the protect pin.
// - Status: bit7 pin enable, bits3:2 block protect, bit1 latch, bit0 busy.
// - Bit0 is one while programming; bit1 mirrors the write-enable latch.
// - Status reads as all ones during a program cycle.
// - Block protect 00 none, 01 top quarter, 10 top half, 11 everything.
// - Protection bits are nonvolatile, need the latch, and use a program cycle.
// - Pin low with pin enable set rejects every status write.
// - Protected addresses never program; others only with the latch set.
// - Read: opcode, two address bytes, then data out MSB first, input ignored.
// - Reads continue with incrementing address, wrapping from top to zero.
// - During programming only the status read is accepted.
// - Programming starts on chip select rising right after a whole byte.
// - Write data advances the six low address bits only, overwriting on wrap.
// - Finishing a program cycle clears the write-enable latch.
// - Write without latch is ignored until the next chip select falling edge.
// - Only the low address bits of the device size are used.
// - Undefined opcode: ignore input, keep output off until next select.
// - Pin dropping while selected, with pin enable set, aborts a pending status write.
`timescale 1ns/1ps
`include "spi_eeprom_map.vh"

module spi_eeprom_command_core #(
  parameter ADDR_BITS = `ADDR_BITS_SMALL,
  parameter PROG_CYCLES = `WRITE_CYCLE_CLKS,
  parameter CNT_W = `PROG_CNT_BITS
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  input wire wp_n_i,
  output reg so_o,
  output reg so_oe_o
);

  // ----------------------------------------
  // Local codes
  // ----------------------------------------
  localparam PB = `PAGE_BITS;
  localparam PAGE_SIZE = 1 << PB;
  localparam DEPTH = 1 << ADDR_BITS;
  localparam [CNT_W-1:0] PROG_LAST = PROG_CYCLES - 1;

  localparam [2:0] ST_STANDBY = 3'd0;
  localparam [2:0] ST_OPCODE = 3'd1;
  localparam [2:0] ST_ADDR_HI = 3'd2;
  localparam [2:0] ST_ADDR_LO = 3'd3;
  localparam [2:0] ST_READ = 3'd4;
  localparam [2:0] ST_WDATA = 3'd5;
  localparam [2:0] ST_SDATA = 3'd6;
  localparam [2:0] ST_STATUS_OUT = 3'd7;

  localparam [2:0] K_BAD = 3'd0;
  localparam [2:0] K_SET_WL = 3'd1;
  localparam [2:0] K_CLR_WL = 3'd2;
  localparam [2:0] K_ST_RD = 3'd3;
  localparam [2:0] K_ST_WR = 3'd4;
  localparam [2:0] K_RD = 3'd5;
  localparam [2:0] K_WR = 3'd6;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [2:0] op_kind;
    input [7:0] b;
    begin
      case (b & `OPCODE_MASK)
        `SET_WRITE_LATCH_CMD: op_kind = K_SET_WL;
        `CLEAR_WRITE_LATCH_CMD: op_kind = K_CLR_WL;
        `ARRAY_READ_CMD: op_kind = K_RD;
        `ARRAY_WRITE_CMD: op_kind = K_WR;
        `STATUS_READ_CMD: op_kind = K_ST_RD;
        `STATUS_WRITE_CMD: op_kind = K_ST_WR;
        default: op_kind = K_BAD;
      endcase
    end
  endfunction

  // Region by the two top address bits, so it scales with ADDR_BITS
  function is_protected;
    input [ADDR_BITS-1:0] a;
    input [1:0] bp;
    begin
      case (bp)
        2'b01: is_protected = (a[ADDR_BITS-1 -: 2] == 2'b11);
        2'b10: is_protected = a[ADDR_BITS-1];
        2'b11: is_protected = 1'b1;
        default: is_protected = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Synchronised link
  // ----------------------------------------
  wire cs_n_s;
  wire si_s;
  wire wp_n_s;
  wire sck_rise;
  wire sck_fall;
  wire cs_fall;
  wire cs_rise;

  link_sampler u_sampler (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .cs_n_i(cs_n_i),
    .sck_i(sck_i),
    .si_i(si_i),
    .wp_n_i(wp_n_i),
    .cs_n_o(cs_n_s),
    .si_o(si_s),
    .wp_n_o(wp_n_s),
    .sck_rise_o(sck_rise),
    .sck_fall_o(sck_fall),
    .cs_fall_o(cs_fall),
    .cs_rise_o(cs_rise)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [2:0] state;
  reg [2:0] bit_cnt;
  reg [2:0] tx_cnt;
  reg [7:0] rx_sh;
  reg [6:0] tx_sh;
  reg [15:0] addr;
  reg rd_mode;
  reg wel;
  reg pin_en;
  reg [1:0] bp;
  reg busy;
  reg [CNT_W-1:0] prog_cnt;
  reg pend_array;
  reg wr_armed;
  reg st_armed;
  reg [7:0] st_new;
  reg [PAGE_SIZE-1:0] page_valid;
  reg [ADDR_BITS-1:0] pf_addr;
  reg pf_active;

  reg [7:0] mem [0:DEPTH-1];
  reg [7:0] page [0:PAGE_SIZE-1];

  wire [7:0] in_byte = {rx_sh[6:0], si_s};
  wire rx_tick = sck_rise & ~cs_n_s;
  wire byte_done = rx_tick & (bit_cnt == 3'd7);
  wire hw_prot = pin_en & ~wp_n_s;
  wire prog_done = busy & (prog_cnt == PROG_LAST);
  wire page_we = byte_done & (state == ST_WDATA);
  wire commit = prog_done & pend_array;
  wire [7:0] status_byte = busy ? `STATUS_BUSY_VALUE : {pin_en, 3'b000, bp, wel, 1'b0};
  wire tx_tick = sck_fall & ~cs_n_s & ((state == ST_READ) | (state == ST_STATUS_OUT));
  wire buf_pop = tx_tick & (state == ST_READ) & (tx_cnt == 3'd0);
  wire buf_flush = cs_fall | cs_rise | (byte_done & (state == ST_ADDR_LO));
  wire buf_in_ready;
  wire buf_out_valid;
  wire [7:0] buf_out;
  wire [7:0] tx_byte = (state == ST_READ) ? (buf_out_valid ? buf_out : 8'hff) : status_byte;

  // ----------------------------------------
  // Read-ahead buffer: prefetch stalls when both entries are full
  // ----------------------------------------
  byte_buffer2 #(
    .WIDTH(8),
    .DEPTH(2),
    .PTR_W(1)
  ) u_rd_buf (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .flush_i(buf_flush),
    .in_valid_i(pf_active),
    .in_ready_o(buf_in_ready),
    .in_data_i(mem[pf_addr]),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_out)
  );

  // ----------------------------------------
  // Array and page storage; no reset on data
  // ----------------------------------------
  integer i;

  always @(posedge clk_i) begin
    if (page_we) begin
      page[addr[PB-1:0]] <= in_byte;
    end
    if (commit) begin
      for (i = 0; i < PAGE_SIZE; i = i + 1) begin
        if (page_valid[i] && !is_protected({addr[ADDR_BITS-1:PB], i[PB-1:0]}, bp)) begin
          mem[{addr[ADDR_BITS-1:PB], i[PB-1:0]}] <= page[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Read-ahead address
  // ----------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pf_addr <= {ADDR_BITS{1'b0}};
      pf_active <= 1'b0;
    end else if (cs_fall || cs_rise) begin
      pf_active <= 1'b0;
    end else if (byte_done && state == ST_ADDR_LO && rd_mode) begin
      pf_addr <= {addr[ADDR_BITS-1:8], in_byte};
      pf_active <= 1'b1;
    end else if (pf_active && buf_in_ready) begin
      pf_addr <= pf_addr + {{(ADDR_BITS-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_STANDBY;
      bit_cnt <= 3'd0;
      rx_sh <= 8'h00;
      addr <= 16'h0000;
      rd_mode <= 1'b0;
      wel <= 1'b0;
      pin_en <= `PROTECT_PIN_ENABLE_RESET;
      bp <= `BLOCK_PROTECT_RESET;
      busy <= 1'b0;
      prog_cnt <= {CNT_W{1'b0}};
      pend_array <= 1'b0;
      wr_armed <= 1'b0;
      st_armed <= 1'b0;
      st_new <= 8'h00;
      page_valid <= {PAGE_SIZE{1'b0}};
    end else begin
      if (busy) begin
        prog_cnt <= prog_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (prog_done) begin
        busy <= 1'b0;
        wel <= 1'b0;
        page_valid <= {PAGE_SIZE{1'b0}};
        if (!pend_array) begin
          pin_en <= st_new[`PROTECT_PIN_ENABLE_BIT];
          bp <= {st_new[`BLOCK_PROTECT_HI_BIT], st_new[`BLOCK_PROTECT_LO_BIT]};
        end
      end
      // A status write in flight dies if the pin drops while still selected and pin enable is set
      if (!cs_n_s && hw_prot) begin
        st_armed <= 1'b0;
      end
      if (cs_fall) begin
        state <= ST_OPCODE;
        bit_cnt <= 3'd0;
        wr_armed <= 1'b0;
        st_armed <= 1'b0;
        // A write that never programmed must not leak its bytes into the next page
        if (!busy) begin
          page_valid <= {PAGE_SIZE{1'b0}};
        end
      end else if (cs_rise) begin
        state <= ST_STANDBY;
        wr_armed <= 1'b0;
        st_armed <= 1'b0;
        // Only a whole last byte starts programming; busy blocks a second start
        if (!busy && bit_cnt == 3'd0) begin
          if (wr_armed) begin
            busy <= 1'b1;
            prog_cnt <= {CNT_W{1'b0}};
            pend_array <= 1'b1;
          end else if (st_armed && !hw_prot) begin
            busy <= 1'b1;
            prog_cnt <= {CNT_W{1'b0}};
            pend_array <= 1'b0;
          end
        end
      end else if (rx_tick && state != ST_STANDBY) begin
        bit_cnt <= bit_cnt + 3'd1;
        rx_sh <= in_byte;
        if (bit_cnt == 3'd7) begin
          case (state)
            ST_OPCODE: begin
              if (busy && op_kind(in_byte) != K_ST_RD) begin
                state <= ST_STANDBY;
              end else begin
                case (op_kind(in_byte))
                  K_SET_WL: begin
                    wel <= 1'b1;
                    state <= ST_STANDBY;
                  end
                  K_CLR_WL: begin
                    wel <= 1'b0;
                    state <= ST_STANDBY;
                  end
                  K_ST_RD: state <= ST_STATUS_OUT;
                  K_ST_WR: state <= (wel && !hw_prot) ? ST_SDATA : ST_STANDBY;
                  K_RD: begin
                    rd_mode <= 1'b1;
                    state <= ST_ADDR_HI;
                  end
                  K_WR: begin
                    rd_mode <= 1'b0;
                    state <= wel ? ST_ADDR_HI : ST_STANDBY;
                  end
                  default: state <= ST_STANDBY;
                endcase
              end
            end
            ST_ADDR_HI: begin
              addr[15:8] <= in_byte;
              state <= ST_ADDR_LO;
            end
            ST_ADDR_LO: begin
              addr[7:0] <= in_byte;
              state <= rd_mode ? ST_READ : ST_WDATA;
            end
            ST_WDATA: begin
              page_valid[addr[PB-1:0]] <= 1'b1;
              addr[PB-1:0] <= addr[PB-1:0] + {{(PB-1){1'b0}}, 1'b1};
              wr_armed <= 1'b1;
            end
            ST_SDATA: begin
              st_new <= in_byte;
              st_armed <= ~hw_prot;
              state <= ST_STANDBY;
            end
            default: state <= state;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Serial output, shifted on falling clock edges
  // ----------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      so_o <= 1'b1;
      so_oe_o <= 1'b0;
      tx_sh <= 7'h00;
      tx_cnt <= 3'd0;
    end else if (cs_n_s || !((state == ST_READ) || (state == ST_STATUS_OUT))) begin
      so_oe_o <= 1'b0;
      tx_cnt <= 3'd0;
    end else if (tx_tick) begin
      so_oe_o <= 1'b1;
      tx_cnt <= tx_cnt + 3'd1;
      if (tx_cnt == 3'd0) begin
        so_o <= tx_byte[7];
        tx_sh <= tx_byte[6:0];
      end else begin
        so_o <= tx_sh[6];
        tx_sh <= {tx_sh[5:0], 1'b0};
      end
    end
  end

endmodule // spi_eeprom_command_core

/* spi_eeprom_props.sv */
`timescale 1ns/1ps

module spi_eeprom_props (
  input wire clk_i,
  input wire reset_n_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  input wire wp_n_i,
  input wire so_o,
  input wire so_oe_o
);
  // ----------------------------------------
  // Frame tracking from the raw pins
  // ----------------------------------------
  logic sck_q;
  logic [5:0] nbits;
  logic [7:0] opc;
  wire [7:0] op_m = opc & 8'hf7;
  wire sck_up = sck_i && !sck_q && !cs_n_i;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_q <= 1'b0;
      nbits <= 6'h00;
      opc <= 8'h00;
    end else begin
      sck_q <= sck_i;
      if (cs_n_i) nbits <= 6'h00;
      else if (sck_up && nbits != 6'h3f) nbits <= nbits + 6'h01;
      if (sck_up && nbits < 6'h08) opc <= {opc[6:0], si_i};
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Raw edge is seen a few clocks before the design's synchronised one, hence the
  // one-bit slack in the counts below
  a_odd_opcode_quiet: assert property (nbits >= 6'h08 && op_m != 8'h03 && op_m != 8'h05 |-> !so_oe_o)
    else $error("output driven for a command without read data");
  a_read_after_addr: assert property ($rose(so_oe_o) && op_m == 8'h03 |-> nbits == 6'h18 || nbits == 6'h19)
    else $error("read data driven before the address was complete");
  a_status_after_op: assert property ($rose(so_oe_o) && op_m == 8'h05 |-> nbits == 6'h08 || nbits == 6'h09)
    else $error("status driven at the wrong bit");
  a_read_answer: assert property ($fell(sck_i) && !cs_n_i && nbits == 6'h18 && op_m == 8'h03 |-> ##[1:8] so_oe_o)
    else $error("read data did not start");
  a_status_answer: assert property ($fell(sck_i) && !cs_n_i && nbits == 6'h08 && op_m == 8'h05 |-> ##[1:8] so_oe_o)
    else $error("status byte did not start");
  a_release_on_cs: assert property ($rose(cs_n_i) |-> ##[1:8] !so_oe_o)
    else $error("output still driven after deselect");
  a_idle_quiet: assert property (cs_n_i [*8] |-> !so_oe_o)
    else $error("output driven while deselected");
  a_so_steady: assert property ($fell(sck_i) && so_oe_o && $past(so_oe_o, 3) |-> $stable(so_o) && so_o == $past(so_o, 2))
    else $error("serial output moved near the sampling edge");
  a_reset_quiet: assert property ($rose(reset_n_i) |-> !so_oe_o [*4])
    else $error("output driven right after reset");

  c_read: cover property ($rose(so_oe_o) && op_m == 8'h03);
  c_status: cover property ($rose(so_oe_o) && op_m == 8'h05);
  c_odd: cover property (nbits == 6'h08 && op_m == 8'h13);
  c_page: cover property ($rose(cs_n_i) && op_m == 8'h02 && nbits == 6'h38);
endmodule // spi_eeprom_props

bind spi_eeprom_command_core spi_eeprom_props u_props (.clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i),
  .sck_i(sck_i), .si_i(si_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o));

/* spi_master_model.sv */
`timescale 1ns/1ps

module spi_master_model (
  input wire clk_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  input wire so_i
);
  // ----------------------------------------
  // Mode 0 master, 80 ns link clock, idle low between frames
  // ----------------------------------------
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask

  task automatic start();
    @(negedge clk_i);
    cs_n_o = 1'b0;
    half();
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_o = tx[i];
      half();
      sck_o = 1'b1;
      half();
      rx[i] = so_i;
      sck_o = 1'b0;
    end
  endtask

  // Deselect inside the low phase after the last bit, then let the data line drift
  task automatic stop();
    repeat (2) @(negedge clk_i);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    repeat (8) @(negedge clk_i);
  endtask
endmodule // spi_master_model

/* spi_eeprom_command_core_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("wrong value at %0t: got %h want %h", $time, g, e); end end

module spi_eeprom_command_core_bench;
  logic clk_i;
  logic reset_n_i;
  logic wp_n_i;
  wire cs_n;
  wire sck;
  wire si;
  wire so_o;
  wire so_oe_o;
  // A released output floats, so a missing drive reads back as z
  wire so_line = so_oe_o ? so_o : 1'bz;
  int err_total;
  int checked;
  logic [7:0] rx;

  spi_eeprom_command_core #(.PROG_CYCLES(1000)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o));
  spi_master_model m (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so_line));

  // ----------------------------------------
  // Shared transfers
  // ----------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic op1(input logic [7:0] op);
    m.start();
    m.xfer(op, rx);
    m.stop();
  endtask

  task automatic chk_sr(input logic [7:0] e);
    logic [7:0] s;
    m.start();
    m.xfer(8'h05, rx);
    m.xfer(8'h00, s);
    m.stop();
    `CHK(s, e)
  endtask

  // Polls stay bounded; a busy flag that outlives them counts as a mismatch
  task automatic wait_ready();
    for (int i = 0; i < 40; i++) begin
      m.start();
      m.xfer(8'h05, rx);
      m.xfer(8'h00, rx);
      m.stop();
      if (rx[0] === 1'b0) break;
    end
    `CHK(rx[0], 1'b0)
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input int n);
    m.start();
    m.xfer(8'h02, rx);
    m.xfer(a[15:8], rx);
    m.xfer(a[7:0], rx);
    for (int i = 0; i < n; i++) m.xfer(d[31-8*i -: 8], rx);
    m.stop();
  endtask

  task automatic rd_chk(input logic [7:0] op, input logic [15:0] a, input logic [31:0] e, input int n);
    m.start();
    m.xfer(op, rx);
    m.xfer(a[15:8], rx);
    m.xfer(a[7:0], rx);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hff, rx);
      `CHK(rx, e[31-8*i -: 8])
    end
    m.stop();
  endtask

  task automatic wr_en(input logic [15:0] a, input logic [7:0] d);
    op1(8'h06);
    wr(a, {d, 24'h000000}, 1);
    wait_ready();
  endtask

  task automatic wsr(input logic [7:0] d);
    op1(8'h06);
    m.start();
    m.xfer(8'h01, rx);
    m.xfer(d, rx);
    m.stop();
    wait_ready();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_latch();
    chk_sr(8'h00);
    for (int b = 0; b < 2; b++) begin
      op1({4'h0, b[0], 3'b110});
      chk_sr(8'h02);
      op1({4'h0, b[0], 3'b100});
      chk_sr(8'h00);
    end
    rd_chk(8'h13, 16'h0000, 32'hzz000000, 1);
  endtask

  task automatic s_page();
    op1(8'h06);
    wr(16'h003e, 32'h11223344, 4);
    chk_sr(8'hff);
    wr(16'h0001, 32'h99000000, 1);
    wait_ready();
    chk_sr(8'h00);
    rd_chk(8'h0b, 16'h403e, 32'h11220000, 2);
    rd_chk(8'h03, 16'hc000, 32'h33440000, 2);
    op1(8'h06);
    op1(8'h04);
    wr(16'h0000, 32'h55000000, 1);
    chk_sr(8'h00);
    rd_chk(8'h03, 16'h0000, 32'h33000000, 1);
    wr_en(16'h3fff, 8'h77);
    rd_chk(8'h03, 16'h3fff, 32'h77330000, 2);
  endtask

  task automatic s_prot();
    logic [7:0] lv;
    logic [15:0] ba;
    for (int l = 1; l < 4; l++) begin
      lv = {4'h0, l[1:0], 2'b00};
      ba = 16'h3fff - {l[3:0], 12'h000};
      wsr(lv);
      chk_sr(lv);
      wr_en(16'h3fff, 8'h5a);
      rd_chk(8'h03, 16'h3fff, 32'h77000000, 1);
      if (l == 3) begin
        wr_en(16'h0000, 8'h5a);
        rd_chk(8'h03, 16'h0000, 32'h33000000, 1);
      end else begin
        wr_en(ba, 8'hc0);
        rd_chk(8'h03, ba, 32'hc0000000, 1);
      end
    end
    wsr(8'h00);
    chk_sr(8'h00);
  endtask

  task automatic s_pin();
    wsr(8'h80);
    chk_sr(8'h80);
    @(negedge clk_i) wp_n_i = 1'b0;
    wsr(8'h00);
    chk_sr(8'h82);
    @(negedge clk_i) wp_n_i = 1'b1;
    op1(8'h06);
    m.start();
    m.xfer(8'h01, rx);
    m.xfer(8'h00, rx);
    @(negedge clk_i) wp_n_i = 1'b0;
    repeat (8) @(negedge clk_i);
    wp_n_i = 1'b1;
    m.stop();
    chk_sr(8'h82);
    wsr(8'h00);
    chk_sr(8'h00);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    reset_n_i = 1'b0;
    wp_n_i = 1'b1;
    err_total = 0;
    checked = 0;
    repeat (6) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    s_latch();
    s_page();
    s_prot();
    s_pin();
    end_sim();
  end

  // About 25k cycles are expected; three times that means a hang
  initial begin
    #750000;
    err_total++;
    end_sim();
  end
endmodule // spi_eeprom_command_core_bench
